// file: dv/qer_motor_logic_tb.sv
// Purpose: self-checking bench of the encoder counter, reference clear, commutation and xor path
// Assumes: outputs settle within one cycle; pins take 3 edges to reach the counter
// Notes:   random encoder walks use seed 96; expectations come from the direction table
module qer_motor_logic_tb
   import qer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst_n, fwd, rev, hall, reference_clear_input, filtered_external_trigger;
   logic internal_trigger_input, commutation_soft, counter_run_bit, input_a_polarity, input_b_polarity;
   logic xor_input_select, clear_source_select, commutation_source_select, control_preload_enable;
   logic direction, update_event, commutation_event, trigger_output, capture1_event;
   logic [2:0]              channel_pin, slave_mode_field, master_mode_field;
   logic [1:0]              channel1_capture_select, channel2_select, ph;
   logic [NUM_CH-1:0]       reference_clear_enable, channel_output_reference;
   logic [CNT_W-1:0]        auto_reload_value, counter, capture1_value, ccnt;
   logic [NUM_CH*CNT_W-1:0] compare_value;
   qer_chan_ctl_t [NUM_CH-1:0] chan_preload, chan_active;
   int                      n_mismatch = 0, tests_run = 0, d, k;
   logic                    oa, ob, na, nb, f, r, seen, cap;
   // timer clock, 100 ns period
   always #50 sys_clk = ~sys_clk;
   qer_sensor_model qer_sensor_model_inst (.sys_clk, .rst_n, .fwd, .rev, .hall, .channel_pin);
   qer_motor_logic qer_motor_logic_inst (
      .sys_clk, .rst_n, .channel_pin, .reference_clear_input, .filtered_external_trigger,
      .internal_trigger_input, .commutation_soft, .counter_run_bit, .slave_mode_field,
      .input_a_polarity, .input_b_polarity, .xor_input_select, .auto_reload_value,
      .clear_source_select, .reference_clear_enable, .compare_value, .chan_preload,
      .channel1_capture_select, .channel2_select, .master_mode_field, .commutation_source_select,
      .control_preload_enable, .counter, .direction, .update_event, .channel_output_reference,
      .chan_active, .commutation_event, .trigger_output, .capture1_value, .capture1_event
   );
   // drive point just after the rising edge
   task automatic tick();
      @(posedge sys_clk);
      #10;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", what, e, g);
         n_mismatch++;
      end
   endtask
   task automatic stop_test();
      $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // counting step from the direction table: +1 up, -1 down, 0 no count
   function automatic int enc_delta(logic [2:0] m, logic a0, logic b0, logic a1, logic b1);
      logic ae, up;
      ae = (a0 != a1);
      up = ae ? (a1 != b1) : (b1 == a1);
      if ((ae && m == SMS_ENC_B) || (!ae && m == SMS_ENC_A))
         return 0;
      return up ? 1 : -1;
   endfunction
   // watchdog
   initial begin
      #3_000_000;
      n_mismatch++;
      stop_test();
   end
   // main sequence
   initial begin
      {rst_n, fwd, rev, hall, reference_clear_input, filtered_external_trigger, internal_trigger_input} = '0;
      {commutation_soft, counter_run_bit, input_a_polarity, input_b_polarity, xor_input_select} = '0;
      {clear_source_select, commutation_source_select, control_preload_enable, reference_clear_enable} = '0;
      {slave_mode_field, master_mode_field, channel1_capture_select, channel2_select} = '0;
      chan_preload = '0;
      compare_value = {4{16'hFFFF}};
      d = $urandom(96);
      auto_reload_value = 16'(4 + $urandom_range(0, 7));
      ph = 2'h0;
      ccnt = 16'h0000;
      repeat (3) @(posedge sys_clk);
      #10 rst_n = 1;
      // encoder walks in each counting mode with random polarity and run bit
      for (int m = 1; m <= 3; m++) begin
         counter_run_bit = 0;
         slave_mode_field = m[2:0];
         input_a_polarity = $urandom_range(0, 1);
         input_b_polarity = $urandom_range(0, 1);
         repeat (5) tick();
         repeat (30) begin
            f = $urandom_range(0, 1);
            r = ($urandom_range(0, 4) != 0);
            oa = ph[1] ^ ph[0] ^ input_a_polarity;
            ob = ph[1] ^ input_b_polarity;
            ph = f ? ph + 2'h1 : ph - 2'h1;
            na = ph[1] ^ ph[0] ^ input_a_polarity;
            nb = ph[1] ^ input_b_polarity;
            d = enc_delta(slave_mode_field, oa, ob, na, nb);
            if (r && d > 0)
               ccnt = (ccnt >= auto_reload_value) ? 16'h0000 : ccnt + 16'h0001;
            if (r && d < 0)
               ccnt = (ccnt == 16'h0000) ? auto_reload_value : ccnt - 16'h0001;
            counter_run_bit = r;
            fwd = f;
            rev = !f;
            tick();
            {fwd, rev} = 2'b00;
            repeat (5) tick();
            chk("counter", ccnt, counter);
            if (r)
               chk("direction", enc_delta(SMS_ENC_2, oa, ob, na, nb) < 0, direction);
         end
         $display("test encoder mode %0d done", m);
      end
      // reference clear from each source; ch3 forced, ch4 not enabled
      counter_run_bit = 0;
      slave_mode_field = SMS_OFF;
      auto_reload_value = 16'h0013;
      chan_preload = {{OCM_PWM1, 1'b1}, {OCM_FORCE_H, 1'b1}, {OCM_PWM1, 1'b1}, {OCM_PWM1, 1'b1}};
      reference_clear_enable = 4'h7;
      master_mode_field = MMS_REF2;
      counter_run_bit = 1;
      repeat (5) tick();
      chk("chan_active", chan_preload, chan_active);
      for (int s = 0; s < 2; s++) begin
         clear_source_select = s[0];
         // the trigger side stands for a comparator on an unprescaled trigger path
         {reference_clear_input, filtered_external_trigger} = s[0] ? 2'b10 : 2'b01;
         repeat (5) tick();
         chk("ref unselected", 4'hF, channel_output_reference);
         for (k = 0; k < 40 && update_event !== 1'b1; k++)
            tick();
         chk("update_event", 1'b1, update_event);
         {reference_clear_input, filtered_external_trigger} = s[0] ? 2'b01 : 2'b10;
         repeat (4) tick();
         chk("ref cleared", 4'hC, channel_output_reference);
         {reference_clear_input, filtered_external_trigger} = 2'b00;
         for (k = 0; k < 40 && update_event !== 1'b1; k++) begin
            chk("ref held", 2'h0, channel_output_reference[1:0]);
            chk("trigger_output", 1'b0, trigger_output);
            tick();
         end
         chk("ref resumed", 4'hF, channel_output_reference);
         chk("trigger_output", 1'b1, trigger_output);
      end
      $display("test reference clear done");
      // commutation: trigger ignored with source 0, taken on rise with source 1, soft request
      control_preload_enable = 1;
      tick();
      chan_preload[3] = {OCM_FORCE_L, 1'b0};
      internal_trigger_input = 1;
      repeat (3) tick();
      chk("active held", {OCM_PWM1, 1'b1}, chan_active[3]);
      for (int s = 0; s < 2; s++) begin
         commutation_source_select = !s[0];
         internal_trigger_input = 0;
         tick();
         internal_trigger_input = !s[0];
         commutation_soft = s[0];
         tick();
         commutation_soft = 0;
         for (k = 0; k < 3 && commutation_event !== 1'b1; k++)
            tick();
         chk("commutation_event", 1'b1, commutation_event);
         chk("chan_active", chan_preload, chan_active);
         chan_preload[3] = {OCM_PWM1, 1'b1};
      end
      $display("test commutation done");
      // xor hall input with reset-mode restart, controller capture and pwm2 delayed pulse
      counter_run_bit = 0;
      control_preload_enable = 0;
      chan_preload[1] = {OCM_PWM2, 1'b1};
      compare_value[2*CNT_W-1:CNT_W] = 16'h0005;
      auto_reload_value = 16'hFFFF;
      xor_input_select = 1;
      slave_mode_field = SMS_RESET;
      channel1_capture_select = CCS_TRC;
      repeat (4) tick();
      counter_run_bit = 1;
      for (int j = 0; j < 8; j++) begin
         d = $urandom_range(10, 40);
         repeat (2) tick();
         if (j > 0)
            chk("trigger low", 1'b0, trigger_output);
         repeat (d - 2) tick();
         chk("trigger high", 1'b1, trigger_output);
         f = $urandom_range(0, 1);
         {hall, fwd} = {f, !f};
         tick();
         {hall, fwd} = 2'b00;
         {seen, cap} = 2'b00;
         for (k = 0; k < 6 && !seen; k++) begin
            tick();
            seen = (update_event === 1'b1);
            cap = cap | (capture1_event === 1'b1);
         end
         chk("restart", 1'b1, seen);
         chk("restart count", 16'h0000, counter);
         chk("capture1_event", 1'b1, cap | (capture1_event === 1'b1));
         // time since the previous restart, counted in bench ticks
         if (j > 0)
            chk("capture1_value", d + k, capture1_value);
      end
      $display("test xor hall done");
      stop_test();
   end
endmodule

// file: dv/qer_sensor_model.sv
// Purpose: incremental encoder and hall sensor stand-in driving the three channel pins
// Assumes: fwd, rev and hall are one-cycle requests from the bench
// Notes:   quadrature phase kept as a 2-bit position, gray coded onto pins a and b
module qer_sensor_model
   import qer_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // motion requests
   input  wire logic       fwd,
   input  wire logic       rev,
   input  wire logic       hall,
   // sensor pins
   output logic [2:0]      channel_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph;
   logic       h;
   // one step moves a single line, so a and b never switch together
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= 2'h0;
         h  <= 1'h0;
      end else begin
         ph <= ph + {rev, fwd | rev};
         h  <= h ^ hall;
      end
   end
   // gray code: 00, 10, 11, 01 for a, b
   assign channel_pin = {h, ph[1], ph[1] ^ ph[0]};
endmodule

// file: hdl/qer_motor_logic.sv
// Purpose: quadrature encoder counter, external reference clear and xor hall input path
// Assumes: pins arrive asynchronously; config ports come from sys_clk logic
// Notes:   counter has no prescaler; one tick per sys_clk when running outside encoder mode
import qer_pkg::*;

// Function
// [R1] enabled channel reference forced low by clear
// [R2] cleared reference stays low until update
// [R3] clear ignored in forced output modes
// [R4] select bit picks clear pin or trigger
// [R5] software sets trigger prescaler off first
// [R6] slave mode picks encoder count inputs
// [R7] polarity bits invert each encoder input
// [R8] encoder counts only with run bit set
// [R9] direction recomputed on any input edge
// [R10] counter wraps between zero and reload
// [R11] compare and trigger output keep working
// [R12] software never mixes encoder and clock2
// [R13] input a counting direction table
// [R14] input b counting direction table
// [R15] both inputs counted, jitter cancels
// [R16] xor of three pins feeds channel 1
// [R17] xor signal usable by capture, trigger
// [R18] reset mode restarts counter on toggle
// [R19] capture select 11 latches on controller signal
// [R20] channel 2 pwm2 makes commutation pulse
// [R21] master mode 101 sends channel 2 ref out
// [R22] trigger rising edge makes commutation event
// [R23] commutation copies preload to active bits
// [R24] pins synchronised before edge detection
module qer_motor_logic (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // pins and on-chip trigger sources
   input  wire logic [2:0]                channel_pin,
   input  wire logic                      reference_clear_input,
   input  wire logic                      filtered_external_trigger,
   input  wire logic                      internal_trigger_input,
   input  wire logic                      commutation_soft,
   // counter configuration
   input  wire logic                      counter_run_bit,
   input  wire logic [2:0]                slave_mode_field,
   input  wire logic                      input_a_polarity,
   input  wire logic                      input_b_polarity,
   input  wire logic                      xor_input_select,
   input  wire logic [CNT_W-1:0]          auto_reload_value,
   // channel configuration
   input  wire logic                      clear_source_select,
   input  wire logic [NUM_CH-1:0]         reference_clear_enable,
   input  wire logic [NUM_CH*CNT_W-1:0]   compare_value,
   input  wire qer_chan_ctl_t [NUM_CH-1:0] chan_preload,
   input  wire logic [1:0]                channel1_capture_select,
   input  wire logic [1:0]                channel2_select,
   input  wire logic [2:0]                master_mode_field,
   input  wire logic                      commutation_source_select,
   input  wire logic                      control_preload_enable,
   // status and outputs
   output logic [CNT_W-1:0]               counter,
   output logic                           direction,
   output logic                           update_event,
   output logic [NUM_CH-1:0]              channel_output_reference,
   output qer_chan_ctl_t [NUM_CH-1:0]     chan_active,
   output logic                           commutation_event,
   output logic                           trigger_output,
   output logic [CNT_W-1:0]               capture1_value,
   output logic                           capture1_event
);

   // one count step with wrap between zero and reload
   function automatic qer_step_t step_count(input logic [CNT_W-1:0] cur, input logic [CNT_W-1:0] top,
                                            input logic down);
      qer_step_t r;
      if (down) begin
         r.wrap  = (cur == CNT_RST);
         r.value = r.wrap ? top : CNT_W'(cur - 1'b1);
      end else begin
         r.wrap  = (cur >= top);
         r.value = r.wrap ? CNT_RST : CNT_W'(cur + 1'b1);
      end
      return r;
   endfunction

   logic [2:0]        pin_meta;
   logic [2:0]        pin_sync;
   logic              clr_meta;
   logic              clr_sync;
   logic              fa_prev;
   logic              fb_prev;
   logic              itr_prev;
   logic [NUM_CH-1:0] clr_hold;
   logic [NUM_CH-1:0] next_hold;
   logic [NUM_CH-1:0] next_ref;
   logic              match1;

   // two-stage synchronisers on all pins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
         clr_meta <= 1'h0;
         clr_sync <= 1'h0;
      end else begin
         pin_meta <= channel_pin; // [R24]
         pin_sync <= pin_meta;
         clr_meta <= reference_clear_input; // [R24]
         clr_sync <= clr_meta;
      end
   end

   // input selection, polarity and edge detection
   wire ti_a_raw  = xor_input_select ? ^pin_sync : pin_sync[0]; // [R16]
   wire fa        = ti_a_raw ^ input_a_polarity; // [R7]
   wire fb        = pin_sync[1] ^ input_b_polarity; // [R7]
   // edges come from the inputs before polarity, so a polarity write never looks like an edge
   wire a_edge    = ti_a_raw ^ fa_prev; // edge of input a, also the controller signal [R17]
   wire b_edge    = pin_sync[1] ^ fb_prev;
   wire a_down    = fa ~^ fb; // [R13]
   wire b_down    = fb ^ fa; // [R14]
   wire enc_dir   = a_edge ? a_down : b_down; // [R15]
   wire any_edge  = a_edge | b_edge;

   // slave mode decode
   wire enc_mode  = (slave_mode_field == SMS_ENC_A) || (slave_mode_field == SMS_ENC_B) ||
                    (slave_mode_field == SMS_ENC_2); // [R6]
   wire cnt_on_a  = (slave_mode_field == SMS_ENC_A) || (slave_mode_field == SMS_ENC_2);
   wire cnt_on_b  = (slave_mode_field == SMS_ENC_B) || (slave_mode_field == SMS_ENC_2);
   wire slave_rst = counter_run_bit && (slave_mode_field == SMS_RESET) && a_edge; // [R18]

   // count step request and direction
   wire enc_step  = counter_run_bit & enc_mode & ((a_edge & cnt_on_a) | (b_edge & cnt_on_b)); // [R8]
   wire free_step = counter_run_bit & ~enc_mode & ~slave_rst;
   wire do_step   = enc_step | free_step;
   wire step_down = enc_mode ? enc_dir : 1'b0;
   qer_step_t nxt;
   assign nxt     = step_count(counter, auto_reload_value, step_down); // [R10]
   wire next_uev  = slave_rst | (do_step & nxt.wrap);

   // counter, direction and update event
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         counter      <= CNT_RST;
         direction    <= DIR_RST;
         update_event <= 1'b0;
         fa_prev      <= 1'b0;
         fb_prev      <= 1'b0;
      end else begin
         fa_prev      <= ti_a_raw;
         fb_prev      <= pin_sync[1];
         update_event <= next_uev;
         if (enc_mode && any_edge)
            direction <= enc_dir; // [R9]
         if (slave_rst)
            counter <= CNT_RST; // [R18]
         else if (do_step)
            counter <= nxt.value; // [R10]
      end
   end

   // commutation: trigger rising edge or software request
   wire itr_rise = internal_trigger_input & ~itr_prev;
   wire next_com = control_preload_enable & (commutation_soft | (commutation_source_select & itr_rise)); // [R22]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         itr_prev          <= 1'b0;
         commutation_event <= 1'b0;
         chan_active       <= '0;
      end else begin
         itr_prev          <= internal_trigger_input;
         commutation_event <= next_com;
         if (!control_preload_enable || next_com)
            chan_active <= chan_preload; // [R23]
      end
   end

   // reference clear source
   wire clr_sig = clear_source_select ? filtered_external_trigger : clr_sync; // [R4]

   // per-channel compare reference with external clear
   always_comb begin
      logic [CNT_W-1:0] ccr;
      logic             match;
      logic             below;
      logic             forced;
      logic             raw;
      ccr       = '0;
      match     = 1'b0;
      below     = 1'b0;
      forced    = 1'b0;
      raw       = 1'b0;
      next_hold = '0;
      next_ref  = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         ccr    = compare_value[i*CNT_W +: CNT_W];
         match  = (counter == ccr);
         below  = (counter < ccr);
         forced = (chan_active[i].mode == OCM_FORCE_L) || (chan_active[i].mode == OCM_FORCE_H);
         unique case (chan_active[i].mode)
            OCM_FROZEN:  raw = channel_output_reference[i];
            OCM_SET:     raw = match | channel_output_reference[i];
            OCM_CLR:     raw = ~match & channel_output_reference[i];
            OCM_TOGGLE:  raw = match ^ channel_output_reference[i];
            OCM_FORCE_L: raw = 1'b0;
            OCM_FORCE_H: raw = 1'b1;
            OCM_PWM1:    raw = below;
            OCM_PWM2:    raw = ~below; // [R20]
         endcase
         if (i == 1 && channel2_select != CCS_OUTPUT)
            raw = 1'b0; // channel 2 in input mode drives no reference
         // set beats the update-event release
         next_hold[i] = ~forced & ((clr_hold[i] & ~next_uev) | (reference_clear_enable[i] & clr_sig)); // [R1] [R2] [R3]
         next_ref[i]  = raw & ~next_hold[i]; // [R1]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_hold                 <= '0;
         channel_output_reference <= '0;
      end else begin
         clr_hold                 <= next_hold; // [R2]
         channel_output_reference <= next_ref; // [R11]
      end
   end

   // channel 1 capture on selected input
   assign match1 = (counter == compare_value[CNT_W-1:0]);
   wire cap_now  = ((channel1_capture_select == CCS_TI_A) && a_edge && fa) ||
                   ((channel1_capture_select == CCS_TI_B) && b_edge && fb) ||
                   ((channel1_capture_select == CCS_TRC) && a_edge); // [R19] [R17]

   // trigger output selection
   logic next_trigger_output;
   always_comb begin
      unique case (master_mode_field)
         MMS_RESET:  next_trigger_output = slave_rst;
         MMS_ENABLE: next_trigger_output = counter_run_bit;
         MMS_UPDATE: next_trigger_output = next_uev;
         MMS_MATCH1: next_trigger_output = match1;
         MMS_REF1:   next_trigger_output = next_ref[0];
         MMS_REF2:   next_trigger_output = next_ref[1]; // [R21]
         MMS_REF3:   next_trigger_output = next_ref[2];
         MMS_REF4:   next_trigger_output = next_ref[3];
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capture1_value <= CNT_RST;
         capture1_event <= 1'b0;
         trigger_output <= 1'b0;
      end else begin
         capture1_event <= cap_now;
         trigger_output <= next_trigger_output; // [R21]
         if (cap_now)
            capture1_value <= counter; // [R19]
      end
   end

   // checks
   a_clear_ref_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
      (reference_clear_enable[0] && clr_sig && chan_active[0].mode == OCM_PWM1) |=> !channel_output_reference[0])
      else $error("enabled clear did not force reference low");
   a_hold_until_update: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
      (clr_hold[0] && !next_uev && chan_active[0].mode == OCM_PWM1) |=> clr_hold[0] && !channel_output_reference[0])
      else $error("cleared reference released before update");
   a_forced_no_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
      (chan_active[2].mode == OCM_FORCE_H) |=> channel_output_reference[2] && !clr_hold[2])
      else $error("forced output was cleared");
   a_run_gate_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
      (!counter_run_bit) |=> $stable(counter))
      else $error("counter moved while stopped");
   a_enc_a_dir: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
      (slave_mode_field == SMS_ENC_A && a_edge && fa && !fb) |=> !direction)
      else $error("input a rise with b low not up");
   a_enc_b_dir: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
      (slave_mode_field == SMS_ENC_B && b_edge && fb && !fa) |=> direction)
      else $error("input b rise with a low not down");
   a_up_wrap_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
      (enc_step && !enc_dir && counter == auto_reload_value) |=> counter == CNT_RST && update_event)
      else $error("up count did not wrap to zero");
   a_reset_mode_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R18]
      slave_rst |=> counter == CNT_RST ##1 1'b1)
      else $error("reset mode toggle did not clear counter");
   a_com_copy: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R23]
      (control_preload_enable && commutation_source_select && itr_rise) |=> commutation_event &&
      chan_active == $past(chan_preload))
      else $error("commutation did not copy preload");
   a_trigger_output_ref2: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R21]
      (master_mode_field == MMS_REF2) |=> trigger_output == channel_output_reference[1])
      else $error("trigger output not channel 2 reference");
   a_pwm2_delay_ref: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R20]
      (chan_active[1].mode == OCM_PWM2 && channel2_select == CCS_OUTPUT && !next_hold[1] &&
      counter >= compare_value[2*CNT_W-1:CNT_W]) |=> channel_output_reference[1])
      else $error("pwm2 reference low past compare");
   a_trc_capture: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R19]
      (channel1_capture_select == CCS_TRC && a_edge) |=> capture1_event && capture1_value == $past(counter))
      else $error("controller edge did not capture counter");
   a_dir_off_input: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
      (slave_mode_field == SMS_ENC_A && b_edge && !a_edge && fb && fa) |=> !direction)
      else $error("direction not updated on uncounted input");
   a_both_a_fall: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
      (slave_mode_field == SMS_ENC_2 && a_edge && !b_edge && !fa && fb) |=> !direction)
      else $error("input a fall with b high not up");

endmodule

// file: hdl/qer_pkg.sv
// Purpose: shared constants and types of the encoder, reference-clear and xor input logic
// Assumes: one timer clock, all fields held steady by software between changes
// Notes:   field encodings are the timer's own codes
package qer_pkg;

   // counter width and channel count
   localparam int CNT_W  = 16;
   localparam int NUM_CH = 4;

   // slave mode field codes
   localparam logic [2:0] SMS_OFF   = 3'h0;
   localparam logic [2:0] SMS_ENC_B = 3'h1;
   localparam logic [2:0] SMS_ENC_A = 3'h2;
   localparam logic [2:0] SMS_ENC_2 = 3'h3;
   localparam logic [2:0] SMS_RESET = 3'h4;

   // channel output compare mode codes
   localparam logic [2:0] OCM_FROZEN  = 3'h0;
   localparam logic [2:0] OCM_SET     = 3'h1;
   localparam logic [2:0] OCM_CLR     = 3'h2;
   localparam logic [2:0] OCM_TOGGLE  = 3'h3;
   localparam logic [2:0] OCM_FORCE_L = 3'h4;
   localparam logic [2:0] OCM_FORCE_H = 3'h5;
   localparam logic [2:0] OCM_PWM1    = 3'h6;
   localparam logic [2:0] OCM_PWM2    = 3'h7;

   // channel 1 capture and channel 2 select codes
   localparam logic [1:0] CCS_OUTPUT = 2'h0;
   localparam logic [1:0] CCS_TI_A   = 2'h1;
   localparam logic [1:0] CCS_TI_B   = 2'h2;
   localparam logic [1:0] CCS_TRC    = 2'h3;

   // master mode field codes
   localparam logic [2:0] MMS_RESET  = 3'h0;
   localparam logic [2:0] MMS_ENABLE = 3'h1;
   localparam logic [2:0] MMS_UPDATE = 3'h2;
   localparam logic [2:0] MMS_MATCH1 = 3'h3;
   localparam logic [2:0] MMS_REF1   = 3'h4;
   localparam logic [2:0] MMS_REF2   = 3'h5;
   localparam logic [2:0] MMS_REF3   = 3'h6;
   localparam logic [2:0] MMS_REF4   = 3'h7;

   // reset values
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic             DIR_RST = 1'h0;

   // per-channel output control, preloaded and active copies
   typedef struct packed {
      logic [2:0] mode;
      logic       enable;
   } qer_chan_ctl_t;

   // next count and wrap flag
   typedef struct packed {
      logic             wrap;
      logic [CNT_W-1:0] value;
   } qer_step_t;

endpackage
